/* verilog/csf_flags.sv */
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - six status flags follow latest alu result while the hold bit is clear
// - carry, overflow, zero, sign feed jumps
// - half-carry and decimal flags never jump conditions
// - user flags change only by explicit writes or interrupt return
// - user flags never offered to jumps
// - reset clears status only, user flags kept
// - interrupt or trap entry pushes flags
// - interrupt return reloads flags from stack
module csf_flags (
  // clock and reset
  input  wire logic                clk_sys,
  input  wire logic                rstn,
  // apb slave
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [7:0]          paddr,
  input  wire logic [31:0]         pwdata,
  input  wire logic [3:0]          pstrb,
  output logic                     pready,
  output logic [31:0]              prdata,
  output logic                     pslverr,
  // datapath result flags
  input  wire logic                alu_upd,
  input  wire logic [5:0]          alu_mask,
  input  wire logic [5:0]          alu_flags,
  // explicit user flag writes
  input  wire logic                uf_wr,
  input  wire logic [1:0]          uf_mask,
  input  wire logic [1:0]          uf_val,
  // conditional jump evaluation
  input  wire csf_pkg::csf_cc_t    jmp_cc,
  input  wire logic                jmp_inv,
  output logic                     jmp_taken,
  // interrupt sequencer
  input  wire logic                entry_push,
  output logic                     push_valid,
  output logic [7:0]               push_data,
  input  wire logic                interrupt_return_op,
  input  wire logic [7:0]          pop_data,
  // current flags
  output logic [7:0]               flags
);

  // flag storage, status part reset, user part not
  logic [5:0]  stat_ff;        // c z s v d h
  logic [1:0]  user_ff;        // uf2 uf1
  logic [5:0]  nxt_stat;       // next status flags
  logic [1:0]  nxt_user;       // next user flags
  // register file state
  logic        hold_ff;        // blocks alu updates when set
  logic [7:0]  saved_ff;       // last value pushed
  logic        push_valid_ff;  // push strobe
  logic [7:0]  push_data_ff;   // pushed value
  logic [31:0] prdata_ff;      // read data
  // apb decode
  logic        acc;            // access phase
  logic        hit_flags;      // flags word addressed
  logic        hit_saved;      // saved word addressed
  logic        hit_ctrl;       // control word addressed
  logic        wr_flags;       // software loads flags
  logic        wr_ctrl;        // software writes control
  logic        bad;            // unmapped or read-only write
  logic [31:0] rd_mux;         // read value

  // the register as seen by everyone
  // bit order assembled
  assign flags = {stat_ff, user_ff};

  // apb access decode, zero wait states
  assign acc       = psel & penable;
  assign hit_flags = (paddr == csf_pkg::OFF_FLAGS);
  assign hit_saved = (paddr == csf_pkg::OFF_SAVED);
  assign hit_ctrl  = (paddr == csf_pkg::OFF_CTRL);
  assign wr_flags  = acc & pwrite & hit_flags & pstrb[0];
  assign wr_ctrl   = acc & pwrite & hit_ctrl & pstrb[0];
  // refused: unmapped word, or a write to the read-only saved word
  assign bad       = ~(hit_flags | hit_saved | hit_ctrl) | (pwrite & hit_saved);
  assign pready    = acc;
  assign pslverr   = acc & bad;
  assign prdata    = prdata_ff;

  // next status flags; return wins, then alu, then software load
  always_comb begin
    nxt_stat = stat_ff;
    if (interrupt_return_op) begin
      nxt_stat = pop_data[csf_pkg::BIT_C:csf_pkg::STAT_LSB];
    end else if (alu_upd && !hold_ff) begin
      nxt_stat = (stat_ff & ~alu_mask) | (alu_flags & alu_mask);
    end else if (wr_flags) begin
      // software load of the whole register
      nxt_stat = pwdata[csf_pkg::BIT_C:csf_pkg::STAT_LSB];
    end
  end

  // next user flags; alu results never reach them
  always_comb begin
    nxt_user = user_ff;
    if (interrupt_return_op) begin
      nxt_user = pop_data[csf_pkg::BIT_UF2:csf_pkg::BIT_UF1];
    end else if (uf_wr) begin
      nxt_user = (user_ff & ~uf_mask) | (uf_val & uf_mask);
    end else if (wr_flags) begin
      nxt_user = pwdata[csf_pkg::BIT_UF2:csf_pkg::BIT_UF1];
    end
  end

  // status flags, cleared by reset
  // status reset
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      stat_ff <= csf_pkg::STAT_RST;
    end else begin
      stat_ff <= nxt_stat;
    end
  end

  alu_update_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    (alu_upd && !hold_ff && !interrupt_return_op)
      |=> ((stat_ff & $past(alu_mask)) == ($past(alu_flags) & $past(alu_mask)))
        && ((stat_ff & ~$past(alu_mask)) == ($past(stat_ff) & ~$past(alu_mask))))
    else $error("status flags missed alu update");

  hold_freeze_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    hold_ff && !interrupt_return_op && !wr_flags |=> $stable(stat_ff))
    else $error("status flags moved while held");

  stat_reset_a: assert property (@(posedge clk_sys)
    !$past(rstn) && rstn |-> (stat_ff == csf_pkg::STAT_RST))
    else $error("status flags not reset");

  carry_pos_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    alu_upd && !hold_ff && !interrupt_return_op
      && alu_mask[csf_pkg::BIT_C - csf_pkg::STAT_LSB]
      |=> flags[csf_pkg::BIT_C] == $past(alu_flags[csf_pkg::BIT_C - csf_pkg::STAT_LSB]))
    else $error("carry flag not in its bit");

  half_pos_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    alu_upd && !hold_ff && !interrupt_return_op
      && alu_mask[csf_pkg::BIT_H - csf_pkg::STAT_LSB]
      |=> flags[csf_pkg::BIT_H] == $past(alu_flags[csf_pkg::BIT_H - csf_pkg::STAT_LSB]))
    else $error("half-carry flag not in its bit");

  // user flags, no reset, power-up value undefined
  // reset untouched
  always_ff @(posedge clk_sys) begin
    user_ff <= nxt_user;
  end

  user_keep_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    !uf_wr && !interrupt_return_op && !wr_flags |=> $stable(user_ff))
    else $error("user flags changed without write");

  user_pos_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    uf_wr && !interrupt_return_op && uf_mask[csf_pkg::BIT_UF2]
      |=> flags[csf_pkg::BIT_UF2] == $past(uf_val[csf_pkg::BIT_UF2]))
    else $error("user flag two not in its bit");

  return_load_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    interrupt_return_op |=> (flags == $past(pop_data)))
    else $error("flags not restored on return");

  flags_write_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    wr_flags && !interrupt_return_op && !uf_wr && !(alu_upd && !hold_ff)
      |=> flags == $past(pwdata[csf_pkg::FLAGS_W-1:0]))
    else $error("software load of flags lost");

  // push strobe and data one cycle after entry request
  // push current flags
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      push_valid_ff <= 1'b0;
      push_data_ff  <= 8'h00;
    end else begin
      push_valid_ff <= entry_push;
      if (entry_push) begin
        push_data_ff <= flags;
      end
    end
  end
  assign push_valid = push_valid_ff;
  assign push_data  = push_data_ff;

  entry_push_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    entry_push |=> push_valid && (push_data == $past(flags)))
    else $error("pushed flags wrong");

  push_pulse_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    !entry_push |=> !push_valid)
    else $error("push strobe without entry");

  // last pushed value, readable for debug
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      saved_ff <= 8'h00;
    end else if (entry_push) begin
      saved_ff <= flags;
    end
  end

  saved_ro_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    acc && pwrite && hit_saved && !entry_push |-> pslverr ##1 $stable(saved_ff))
    else $error("saved word accepted a write");

  // control register: hold bit freezes alu updates
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      hold_ff <= csf_pkg::CTRL_RST;
    end else if (wr_ctrl) begin
      hold_ff <= pwdata[csf_pkg::CTRL_HOLD];
    end
  end

  // read multiplexer, upper bits zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (hit_flags) begin
      rd_mux[csf_pkg::FLAGS_W-1:0] = flags;
    end else if (hit_saved) begin
      rd_mux[csf_pkg::FLAGS_W-1:0] = saved_ff;
    end else if (hit_ctrl) begin
      rd_mux[csf_pkg::CTRL_HOLD] = hold_ff;
    end
  end

  // read data registered in the setup cycle
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      prdata_ff <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata_ff <= rd_mux;
    end
  end

  // condition evaluator link
  csf_cond_if cif ();

  assign cif.tflags = {stat_ff[csf_pkg::BIT_C - csf_pkg::STAT_LSB],
                       stat_ff[csf_pkg::BIT_Z - csf_pkg::STAT_LSB],
                       stat_ff[csf_pkg::BIT_S - csf_pkg::STAT_LSB],
                       stat_ff[csf_pkg::BIT_V - csf_pkg::STAT_LSB]};
  assign cif.sel    = jmp_cc;
  assign cif.inv    = jmp_inv;
  assign jmp_taken  = cif.taken;

  carry_jump_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    (jmp_cc == csf_pkg::CSF_CC_C) |-> (jmp_taken == (flags[csf_pkg::BIT_C] ^ jmp_inv)))
    else $error("carry jump verdict wrong");

  zero_jump_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    (jmp_cc == csf_pkg::CSF_CC_Z) |-> (jmp_taken == (flags[csf_pkg::BIT_Z] ^ jmp_inv)))
    else $error("zero jump verdict wrong");

  sign_jump_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    (jmp_cc == csf_pkg::CSF_CC_S) |-> (jmp_taken == (flags[csf_pkg::BIT_S] ^ jmp_inv)))
    else $error("sign jump verdict wrong");

  ovf_jump_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    (jmp_cc == csf_pkg::CSF_CC_V) |-> (jmp_taken == (flags[csf_pkg::BIT_V] ^ jmp_inv)))
    else $error("overflow jump verdict wrong");

  bcd_nojump_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    $changed(flags[csf_pkg::BIT_D:csf_pkg::BIT_H])
      && $stable(flags[csf_pkg::BIT_C:csf_pkg::BIT_V])
      && $stable(jmp_cc) && $stable(jmp_inv) |-> $stable(jmp_taken))
    else $error("decimal flag altered jump verdict");

  user_nojump_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    $changed(user_ff) && $stable(flags[csf_pkg::BIT_C:csf_pkg::BIT_H])
      && $stable(jmp_cc) && $stable(jmp_inv) |-> $stable(jmp_taken))
    else $error("user flag altered jump verdict");

  // evaluator instance
  csf_cond_eval u_eval (
    .cif (cif.eval)
  );

endmodule : csf_flags
`default_nettype wire

/* shared/csf_pkg.sv */
// shared constants for the cpu status flags register
package csf_pkg;

  // register width and flag bit positions, carry in the top bit
  localparam int unsigned FLAGS_W   = 8;
  localparam int unsigned BIT_C     = 7;
  localparam int unsigned BIT_Z     = 6;
  localparam int unsigned BIT_S     = 5;
  localparam int unsigned BIT_V     = 4;
  localparam int unsigned BIT_D     = 3;
  localparam int unsigned BIT_H     = 2;
  localparam int unsigned BIT_UF2   = 1;
  localparam int unsigned BIT_UF1   = 0;

  // status flags occupy the top six bits, user flags the bottom two
  localparam int unsigned STAT_W    = 6;
  localparam int unsigned STAT_LSB  = 2;
  localparam int unsigned USER_W    = 2;

  // reset value of the six status flags
  localparam logic [5:0]  STAT_RST  = 6'h00;

  // apb map, byte addresses of aligned words
  localparam int unsigned ADDR_W    = 8;
  localparam int unsigned DATA_W    = 32;
  localparam logic [7:0]  OFF_FLAGS = 8'h00;
  localparam logic [7:0]  OFF_SAVED = 8'h04;
  localparam logic [7:0]  OFF_CTRL  = 8'h08;

  // control register fields
  localparam int unsigned CTRL_HOLD = 0;
  localparam logic        CTRL_RST  = 1'b0;

  // jump conditions; only the four testable flags can be named
  typedef enum logic [2:0] {
    CSF_CC_NEVER  = 3'h0,
    CSF_CC_ALWAYS = 3'h1,
    CSF_CC_C      = 3'h2,
    CSF_CC_Z      = 3'h3,
    CSF_CC_S      = 3'h4,
    CSF_CC_V      = 3'h5
  } csf_cc_t;

endpackage : csf_pkg

/* shared/csf_cond_if.sv */
`timescale 1ns/1ps
`default_nettype none
// carries the testable flags to the condition evaluator and the verdict back
interface csf_cond_if;
  logic [3:0]      tflags;   // c, z, s, v in that order from bit 3
  csf_pkg::csf_cc_t sel;     // condition asked for
  logic            inv;      // branch on the flag being clear
  logic            taken;    // verdict

  modport owner (output tflags, output sel, output inv, input taken);
  modport eval  (input tflags, input sel, input inv, output taken);
endinterface : csf_cond_if
`default_nettype wire

/* verilog/csf_cond_eval.sv */
`timescale 1ns/1ps
`default_nettype none
// combinational condition evaluator for conditional jumps
module csf_cond_eval (
  // flags in, verdict out
  csf_cond_if.eval cif
);

  // raw selection before polarity
  logic raw;

  // pick one of the four testable flags; nothing else can be reached
  always_comb begin
    case (cif.sel)
      csf_pkg::CSF_CC_NEVER:  raw = 1'b0;
      csf_pkg::CSF_CC_ALWAYS: raw = 1'b1;
      csf_pkg::CSF_CC_C:      raw = cif.tflags[3];
      csf_pkg::CSF_CC_Z:      raw = cif.tflags[2];
      csf_pkg::CSF_CC_S:      raw = cif.tflags[1];
      csf_pkg::CSF_CC_V:      raw = cif.tflags[0];
      default:                raw = 1'b0;
    endcase
  end

  // polarity flips the verdict
  assign cif.taken = raw ^ cif.inv;

endmodule : csf_cond_eval
`default_nettype wire

/* testbench/csf_seq_model.sv */
`timescale 1ns/1ps
`default_nettype none
// interrupt sequencer stand-in: keeps pushed flag bytes on a stack
module csf_seq_model (
  // clock
  input  wire logic       clk_sys,
  // push side from the flags block
  input  wire logic       push_valid,
  input  wire logic [7:0] push_data,
  // return side
  input  wire logic       pop_req,
  output logic [7:0]      pop_data
);
  logic [7:0] stack_q[$];  // saved flag bytes, newest last
  initial pop_data = 8'h00;
  always @(posedge clk_sys) begin
    if (push_valid) begin
      stack_q.push_back(push_data);
      pop_data <= push_data;
    end else if (pop_req && stack_q.size() > 0) begin
      void'(stack_q.pop_back());
      // empty stack shows a changed pattern, not the stale byte
      pop_data <= (stack_q.size() > 0) ? stack_q[$] : ~pop_data;
    end
  end
endmodule : csf_seq_model
`default_nettype wire

/* testbench/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  // clock, reset and apb
  logic             clk_sys, rstn, psel, penable, pwrite, pready, pslverr, er, hold;
  logic [7:0]       paddr;
  logic [31:0]      pwdata, prdata, rd, rnd;
  logic [3:0]       pstrb;
  // datapath, jump and sequencer
  logic             alu_upd, uf_wr, jmp_inv, jmp_taken, entry_push, push_valid;
  logic             interrupt_return_op;
  logic [5:0]       alu_mask, alu_flags;
  logic [1:0]       uf_mask, uf_val;
  logic [7:0]       push_data, pop_data, flags, m, saved;
  csf_pkg::csf_cc_t jmp_cc;
  int               failures, samples_checked, seed;

  csf_flags u_csf_flags (.clk_sys, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
    .pready, .prdata, .pslverr, .alu_upd, .alu_mask, .alu_flags, .uf_wr, .uf_mask, .uf_val,
    .jmp_cc, .jmp_inv, .jmp_taken, .entry_push, .push_valid, .push_data,
    .interrupt_return_op, .pop_data, .flags);
  csf_seq_model u_csf_seq_model (.clk_sys, .push_valid, .push_data,
    .pop_req(interrupt_return_op), .pop_data);

  // free running system clock
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : cyc

  // compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic results;
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : results

  // one apb transfer, waits for pready under a bound
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    cyc(1);
    penable <= 1'b1;
    n = 0;
    do begin
      cyc(1);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) begin
      failures++;
      results();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    cyc(1);
  endtask : apb

  // datapath pulse, model update, then compare the register
  task automatic dp(input logic a, input logic [5:0] am, af,
                    input logic u, input logic [1:0] um, uv);
    alu_upd <= a; alu_mask <= am; alu_flags <= af;
    uf_wr <= u; uf_mask <= um; uf_val <= uv;
    cyc(1);
    alu_upd <= 1'b0; uf_wr <= 1'b0;
    if (a && !hold) m[7:2] = (m[7:2] & ~am) | (af & am);
    if (u) m[1:0] = (m[1:0] & ~um) | (uv & um);
    cyc(1);
    chk(flags, m);
  endtask : dp

  // expected verdict: codes 2..5 pick bits 7..4; codes 6, 7, h, d and user bits never
  function automatic logic jexp(input logic [7:0] f, input int c, input logic i);
    if (c < 2) return c[0];
    if (c > 5) return 1'b0;
    return f[9 - c] ^ i;
  endfunction : jexp

  // every condition code, both polarities where it tests a flag
  task automatic jumps;
    for (int c = 0; c < 8; c++) begin
      for (int i = 0; i < 2; i++) begin
        jmp_cc <= csf_pkg::csf_cc_t'(c);
        jmp_inv <= (c > 1 && c < 6) ? i[0] : 1'b0;
        cyc(1);
        chk(jmp_taken, jexp(m, c, (c > 1 && c < 6) ? i[0] : 1'b0));
      end
    end
  endtask : jumps

  initial begin
    seed = 32'h03686548;
    {psel, penable, pwrite, alu_upd, uf_wr, jmp_inv, entry_push, interrupt_return_op} = '0;
    paddr = 8'h00; pwdata = 32'h0; pstrb = 4'hf; hold = 1'b0;
    alu_mask = 6'h00; alu_flags = 6'h00; uf_mask = 2'h0; uf_val = 2'h0;
    jmp_cc = csf_pkg::CSF_CC_NEVER; failures = 0; samples_checked = 0;
    rstn = 1'b0;
    cyc(12);
    rstn <= 1'b1;
    cyc(1);
    chk(flags[7:2], 6'h00);
    m = {6'h00, 2'bxx};
    dp(1'b0, 6'h00, 6'h00, 1'b1, 2'h3, 2'h2);
    $display("reset test done");
    for (int k = 0; k < 30; k++) begin
      rnd = $random(seed);
      dp(1'b1, rnd[5:0], rnd[11:6], k[0], rnd[13:12], rnd[15:14]);
      jumps();
    end
    $display("datapath test done");
    entry_push <= 1'b1;
    cyc(1);
    entry_push <= 1'b0;
    cyc(1);
    chk(push_valid, 1'b1);
    chk(push_data, m);
    saved = m;
    cyc(1);
    chk(push_valid, 1'b0);
    dp(1'b1, 6'h3f, ~m[7:2], 1'b1, 2'h3, ~m[1:0]);
    interrupt_return_op <= 1'b1;
    cyc(1);
    interrupt_return_op <= 1'b0;
    m = saved;
    cyc(1);
    chk(flags, m);
    $display("interrupt test done");
    apb(1'b1, csf_pkg::OFF_FLAGS, 32'h0000_00a5);
    m = 8'ha5;
    chk(er, 1'b0);
    apb(1'b0, csf_pkg::OFF_FLAGS, 32'h0);
    chk(rd, {24'h0, m});
    jumps();
    apb(1'b0, csf_pkg::OFF_SAVED, 32'h0);
    chk(rd, {24'h0, saved});
    apb(1'b1, csf_pkg::OFF_SAVED, 32'h0000_0011);
    chk(er, 1'b1);
    apb(1'b0, 8'h0c, 32'h0);
    chk(er, 1'b1);
    apb(1'b1, csf_pkg::OFF_CTRL, 32'h1);
    hold = 1'b1;
    apb(1'b0, csf_pkg::OFF_CTRL, 32'h0);
    chk(rd, 32'h1 << csf_pkg::CTRL_HOLD);
    dp(1'b1, 6'h3f, ~m[7:2], 1'b1, 2'h1, ~m[1:0]);
    apb(1'b1, csf_pkg::OFF_CTRL, 32'h0);
    hold = 1'b0;
    // a write without its low byte strobe leaves the flags alone
    pstrb <= 4'h0;
    apb(1'b1, csf_pkg::OFF_FLAGS, {24'h0, ~m});
    pstrb <= 4'hf;
    apb(1'b0, csf_pkg::OFF_FLAGS, 32'h0);
    chk(rd, {24'h0, m});
    $display("register test done");
    rstn <= 1'b0;
    cyc(2);
    rstn <= 1'b1;
    cyc(1);
    m[7:2] = 6'h00;
    chk(flags, m);
    $display("second reset test done");
    results();
  end
endmodule : tb_top
`default_nettype wire
